// ### srf_defines.svh
// Constants for the subroutine and flag execution unit
`ifndef SRF_DEFINES_SVH
`define SRF_DEFINES_SVH
`define SRF_BIT_I 7
`define SRF_BIT_H 5
`define SRF_BIT_N 3
`define SRF_BIT_Z 2
`define SRF_BIT_V 1
`define SRF_BIT_C 0
`define SRF_CCR_RST 8'h80
`define SRF_PC_RST 16'h0000
`define SRF_SP_RST 16'hFF00
`define SRF_SP_STEP 16'h0002
`define SRF_LEN_SHORT 16'h0002
`define SRF_LEN_ABS 16'h0004
`define SRF_VEC_PAGE 8'h00
`define SRF_ST_CALL_REG 11'h006
`define SRF_ST_CALL_ABS 11'h008
`define SRF_ST_CALL_MEM 11'h008
`define SRF_ST_RET 11'h008
`define SRF_ST_RET_EXC 11'h00A
`define SRF_ST_SHORT 11'h002
`define SRF_ST_BM_BASE 11'h008
`define SRF_DEC_MAX 8'h99
`endif

// ### srf_pkg.sv
// Types for the subroutine and flag execution unit
`default_nettype none
package srf_pkg;
	typedef enum logic [3:0] {
		OP_CALL_REG, OP_CALL_ABS, OP_CALL_MEM, OP_RET, OP_RET_EXC,
		OP_SLEEP, OP_LOAD_FLAGS_IMM, OP_LOAD_FLAGS_REG, OP_STORE_FLAGS,
		OP_AND_FLAGS, OP_OR_FLAGS, OP_XOR_FLAGS, OP_NOP, OP_BLOCK_MOVE
	} srf_op_t;
	typedef enum logic [2:0] {
		FOP_ADD_W, FOP_SUB_W, FOP_ADD_CARRY, FOP_SUB_BORROW,
		FOP_DEC_ADD, FOP_DEC_SUB, FOP_DIV_U
	} srf_fop_t;
	typedef enum logic [2:0] {
		PH_INT, PH_PUSH, PH_POPPC, PH_POPCCR, PH_VEC, PH_MOVE, PH_END
	} srf_ph_t;
endpackage
`default_nettype wire

// ### srf_flag_if.sv
// Carrier between the sequencer and the flag unit
`timescale 1ns/10ps
`default_nettype none
interface srf_flag_if;
	srf_pkg::srf_fop_t op;
	logic [15:0]       a;
	logic [15:0]       b;
	logic [7:0]        ccr_in;
	logic [7:0]        ccr_out;
	modport cpu (output op, output a, output b, output ccr_in, input ccr_out);
	modport unit (input op, input a, input b, input ccr_in, output ccr_out);
endinterface
`default_nettype wire

// ### srf_flag_unit.sv
// Flag update for word, extended, decimal and divide results
`timescale 1ns/10ps
`default_nettype none
`include "srf_defines.svh"
module srf_flag_unit (
	srf_flag_if.unit fl
);
	// Only the flags named per operation change; the rest come from the ALU elsewhere
	always_comb begin
		logic [12:0] hsum;
		logic [8:0]  ext;
		hsum = 13'h0000;
		ext = 9'h000;
		fl.ccr_out = fl.ccr_in;
		case (fl.op)
			srf_pkg::FOP_ADD_W: begin
				hsum = {1'b0, fl.a[11:0]} + {1'b0, fl.b[11:0]};
				fl.ccr_out[`SRF_BIT_H] = hsum[12];
			end
			srf_pkg::FOP_SUB_W: begin
				fl.ccr_out[`SRF_BIT_H] = (fl.a[11:0] < fl.b[11:0]);
			end
			srf_pkg::FOP_ADD_CARRY: begin
				ext = {1'b0, fl.a[7:0]} + {1'b0, fl.b[7:0]} + {8'h00, fl.ccr_in[`SRF_BIT_C]};
				if (ext[7:0] != 8'h00) begin
					fl.ccr_out[`SRF_BIT_Z] = 1'b0;
				end
			end
			srf_pkg::FOP_SUB_BORROW: begin
				ext = {1'b0, fl.a[7:0]} - {1'b0, fl.b[7:0]} - {8'h00, fl.ccr_in[`SRF_BIT_C]};
				if (ext[7:0] != 8'h00) begin
					fl.ccr_out[`SRF_BIT_Z] = 1'b0;
				end
			end
			srf_pkg::FOP_DEC_ADD: begin
				fl.ccr_out[`SRF_BIT_C] = fl.ccr_in[`SRF_BIT_C] | (fl.a[7:0] > `SRF_DEC_MAX);
			end
			srf_pkg::FOP_DEC_SUB: begin
				fl.ccr_out[`SRF_BIT_C] = fl.ccr_in[`SRF_BIT_C];
			end
			srf_pkg::FOP_DIV_U: begin
				fl.ccr_out[`SRF_BIT_N] = fl.b[7];
				// Zero divisor leaves Z as it was, which is one legal undefined value
				if (fl.b[7:0] != 8'h00) begin
					fl.ccr_out[`SRF_BIT_Z] = 1'b0;
				end
			end
			default: begin
				fl.ccr_out = fl.ccr_in;
			end
		endcase
	end
endmodule
`default_nettype wire

// ### srf_exec_unit.sv
// Execution sequencer for calls, returns, sleep and flag transfers
`timescale 1ns/10ps
`default_nettype none
`include "srf_defines.svh"
module srf_exec_unit (
	input  wire logic              SYS_CLK_I,
	input  wire logic              RESETN_I,
	input  wire logic              INSTR_VALID_I,
	input  wire srf_pkg::srf_op_t  INSTR_OP_I,
	input  wire logic [15:0]       INSTR_IMM_I,
	input  wire logic [15:0]       INSTR_REG_I,
	input  wire logic [15:0]       BM_SRC_I,
	input  wire logic [15:0]       BM_DST_I,
	input  wire logic [7:0]        BM_COUNT_I,
	input  wire logic              WAKE_I,
	input  wire logic              FLAG_VALID_I,
	input  wire srf_pkg::srf_fop_t FLAG_OP_I,
	input  wire logic [15:0]       FLAG_A_I,
	input  wire logic [15:0]       FLAG_B_I,
	input  wire logic [15:0]       MEM_RDATA_I,
	input  wire logic              MEM_READY_I,
	output logic                   INSTR_READY_O,
	output logic                   DONE_O,
	output logic                   SLEEP_O,
	output logic [7:0]             CCR_O,
	output logic [15:0]            PC_O,
	output logic [15:0]            SP_O,
	output logic                   REG_WE_O,
	output logic [7:0]             REG_WDATA_O,
	output logic [15:0]            MEM_ADDR_O,
	output logic [15:0]            MEM_WDATA_O,
	output logic                   MEM_RD_O,
	output logic                   MEM_WR_O,
	output logic                   MEM_WORD_O
);
	// -------------------------
	// Declarations
	// -------------------------
	typedef enum logic [1:0] {S_IDLE, S_RUN, S_SLEEP} srf_st_t;

	srf_st_t           st_reg;
	srf_pkg::srf_op_t  op_reg;
	logic [2:0]        idx_reg;
	logic [1:0]        sub_reg;
	logic [7:0]        left_reg;
	logic [7:0]        bmc_reg;
	logic              nomove_reg;
	logic [15:0]       imm_reg;
	logic [15:0]       rn_reg;
	logic [15:0]       src_reg;
	logic [15:0]       dst_reg;
	logic [15:0]       vec_reg;
	logic [15:0]       ret_reg;
	logic [15:0]       pc_reg;
	logic [15:0]       sp_reg;
	logic [7:0]        ccr_reg;
	logic [10:0]       cnt_reg;
	logic              waited_reg;
	logic              done_reg;
	logic              sleep_reg;
	logic              ready_reg;
	logic              we_reg;
	logic [7:0]        wdat_reg;
	logic [15:0]       addr_reg;
	logic [15:0]       mwd_reg;
	logic              rd_reg;
	logic              wr_reg;
	logic              word_reg;
	srf_pkg::srf_ph_t  ph;
	srf_pkg::srf_ph_t  nph;
	logic              is_mem;
	logic              step;
	logic              pdone;
	logic              fin;
	logic              start;
	logic              flag_take;
	logic [1:0]        sub_next;
	logic [10:0]       exp_states;

	srf_flag_if fl ();

	srf_flag_unit u_flag (
		.fl (fl.unit)
	);

	assign fl.op     = FLAG_OP_I;
	assign fl.a      = FLAG_A_I;
	assign fl.b      = FLAG_B_I;
	assign fl.ccr_in = ccr_reg;

	// -------------------------
	// Phase schedule
	// -------------------------
	// Each phase is two states, a move phase four per byte; a memory phase stretches while MEM_READY_I is low
	function automatic srf_pkg::srf_ph_t phase_of(
		input srf_pkg::srf_op_t op,
		input logic [2:0]       ix,
		input logic             nm
	);
		phase_of = srf_pkg::PH_END;
		case (op)
			srf_pkg::OP_CALL_REG: begin
				if (ix == 3'h0 || ix == 3'h2) phase_of = srf_pkg::PH_INT;
				else if (ix == 3'h1) phase_of = srf_pkg::PH_PUSH;
			end
			srf_pkg::OP_CALL_ABS: begin
				if (ix == 3'h0 || ix == 3'h1 || ix == 3'h3) phase_of = srf_pkg::PH_INT;
				else if (ix == 3'h2) phase_of = srf_pkg::PH_PUSH;
			end
			srf_pkg::OP_CALL_MEM: begin
				if (ix == 3'h0 || ix == 3'h3) phase_of = srf_pkg::PH_INT;
				else if (ix == 3'h1) phase_of = srf_pkg::PH_VEC;
				else if (ix == 3'h2) phase_of = srf_pkg::PH_PUSH;
			end
			srf_pkg::OP_RET: begin
				if (ix == 3'h1) phase_of = srf_pkg::PH_POPPC;
				else if (ix <= 3'h3) phase_of = srf_pkg::PH_INT;
			end
			srf_pkg::OP_RET_EXC: begin
				if (ix == 3'h1) phase_of = srf_pkg::PH_POPCCR;
				else if (ix == 3'h2) phase_of = srf_pkg::PH_POPPC;
				else if (ix <= 3'h4) phase_of = srf_pkg::PH_INT;
			end
			srf_pkg::OP_BLOCK_MOVE: begin
				// A zero count drops only the move phase; the other four phases stay internal
				if (ix == 3'h2) phase_of = nm ? srf_pkg::PH_INT : srf_pkg::PH_MOVE;
				else if (ix == 3'h4) phase_of = nm ? srf_pkg::PH_END : srf_pkg::PH_INT;
				else if (ix <= 3'h3) phase_of = srf_pkg::PH_INT;
			end
			default: begin
				if (ix == 3'h0) phase_of = srf_pkg::PH_INT;
			end
		endcase
	endfunction

	always_comb begin
		ph = phase_of(op_reg, idx_reg, nomove_reg);
		is_mem = (ph != srf_pkg::PH_INT) && (ph != srf_pkg::PH_END);
		step = (st_reg == S_RUN) && sub_reg[0] && (!is_mem || MEM_READY_I);
		pdone = step && ((ph != srf_pkg::PH_MOVE) || (sub_reg == 2'h3 && left_reg == 8'h01));
		nph = pdone ? phase_of(op_reg, idx_reg + 3'h1, nomove_reg) : ph;
		fin = pdone && (nph == srf_pkg::PH_END);
		start = (st_reg == S_IDLE) && INSTR_VALID_I;
		flag_take = (st_reg == S_IDLE) && !INSTR_VALID_I && FLAG_VALID_I;
		if (pdone) sub_next = 2'h0;
		else if (!sub_reg[0] || step) sub_next = sub_reg + 2'h1;
		else sub_next = sub_reg;
	end

	// -------------------------
	// Control state
	// -------------------------
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			st_reg <= S_IDLE;
		end else begin
			case (st_reg)
				S_IDLE: if (start) st_reg <= S_RUN;
				S_RUN: begin
					if (fin) st_reg <= (op_reg == srf_pkg::OP_SLEEP) ? S_SLEEP : S_IDLE;
				end
				S_SLEEP: if (WAKE_I) st_reg <= S_IDLE;
				default: st_reg <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			idx_reg <= 3'h0;
			sub_reg <= 2'h0;
			left_reg <= 8'h00;
			src_reg <= 16'h0000;
			dst_reg <= 16'h0000;
		end else if (start) begin
			idx_reg <= 3'h0;
			sub_reg <= 2'h0;
			left_reg <= BM_COUNT_I;
			src_reg <= BM_SRC_I;
			dst_reg <= BM_DST_I;
		end else if (st_reg == S_RUN) begin
			sub_reg <= sub_next;
			if (pdone) idx_reg <= idx_reg + 3'h1;
			if (ph == srf_pkg::PH_MOVE && step && sub_reg == 2'h3) begin
				left_reg <= left_reg - 8'h01;
				src_reg <= src_reg + 16'h0001;
				dst_reg <= dst_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			op_reg <= srf_pkg::OP_NOP;
			imm_reg <= 16'h0000;
			rn_reg <= 16'h0000;
			ret_reg <= 16'h0000;
			bmc_reg <= 8'h00;
			nomove_reg <= 1'b1;
		end else if (start) begin
			op_reg <= INSTR_OP_I;
			imm_reg <= INSTR_IMM_I;
			rn_reg <= INSTR_REG_I;
			bmc_reg <= BM_COUNT_I;
			nomove_reg <= (BM_COUNT_I == 8'h00);
			// The absolute call is the only four-byte form here
			ret_reg <= pc_reg + ((INSTR_OP_I == srf_pkg::OP_CALL_ABS) ?
				`SRF_LEN_ABS : `SRF_LEN_SHORT);
		end
	end

	// -------------------------
	// Memory port
	// -------------------------
	// Requests are registered one edge ahead so that the pins come straight from flops
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I || st_reg != S_RUN || fin) begin
			rd_reg <= 1'b0;
			wr_reg <= 1'b0;
			word_reg <= 1'b0;
			addr_reg <= 16'h0000;
			mwd_reg <= 16'h0000;
		end else begin
			rd_reg <= (nph == srf_pkg::PH_POPPC) || (nph == srf_pkg::PH_POPCCR) ||
				(nph == srf_pkg::PH_VEC) || (nph == srf_pkg::PH_MOVE && !sub_next[1]);
			wr_reg <= (nph == srf_pkg::PH_PUSH) || (nph == srf_pkg::PH_MOVE && sub_next[1]);
			word_reg <= (nph != srf_pkg::PH_MOVE) && (nph != srf_pkg::PH_INT);
			case (nph)
				srf_pkg::PH_PUSH: begin
					addr_reg <= {sp_reg[15:1] - 15'h0001, 1'b0};
					mwd_reg <= ret_reg;
				end
				srf_pkg::PH_POPPC, srf_pkg::PH_POPCCR: begin
					addr_reg <= {sp_reg[15:1], 1'b0};
				end
				srf_pkg::PH_VEC: begin
					addr_reg <= {`SRF_VEC_PAGE, imm_reg[7:1], 1'b0};
				end
				srf_pkg::PH_MOVE: begin
					addr_reg <= sub_next[1] ? dst_reg : src_reg;
					if (ph == srf_pkg::PH_MOVE && step && sub_reg == 2'h1) begin
						mwd_reg <= {8'h00, MEM_RDATA_I[7:0]};
					end
				end
				default: addr_reg <= 16'h0000;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			vec_reg <= 16'h0000;
		end else if (step && (ph == srf_pkg::PH_VEC || ph == srf_pkg::PH_POPPC)) begin
			vec_reg <= MEM_RDATA_I;
		end
	end

	// -------------------------
	// Program counter, stack and flags
	// -------------------------
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			sp_reg <= `SRF_SP_RST;
		end else if (step && ph == srf_pkg::PH_PUSH) begin
			sp_reg <= sp_reg - `SRF_SP_STEP;
		end else if (step && (ph == srf_pkg::PH_POPPC || ph == srf_pkg::PH_POPCCR)) begin
			sp_reg <= sp_reg + `SRF_SP_STEP;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			pc_reg <= `SRF_PC_RST;
		end else if (fin) begin
			case (op_reg)
				srf_pkg::OP_CALL_REG: pc_reg <= rn_reg;
				srf_pkg::OP_CALL_ABS: pc_reg <= imm_reg;
				srf_pkg::OP_CALL_MEM: pc_reg <= vec_reg;
				srf_pkg::OP_RET: pc_reg <= vec_reg;
				srf_pkg::OP_RET_EXC: pc_reg <= vec_reg;
				default: pc_reg <= ret_reg;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			ccr_reg <= `SRF_CCR_RST;
		end else if (step && ph == srf_pkg::PH_POPCCR) begin
			ccr_reg <= MEM_RDATA_I[7:0];
		end else if (fin) begin
			case (op_reg)
				srf_pkg::OP_LOAD_FLAGS_IMM: ccr_reg <= imm_reg[7:0];
				srf_pkg::OP_LOAD_FLAGS_REG: ccr_reg <= rn_reg[7:0];
				srf_pkg::OP_AND_FLAGS: ccr_reg <= ccr_reg & imm_reg[7:0];
				srf_pkg::OP_OR_FLAGS: ccr_reg <= ccr_reg | imm_reg[7:0];
				srf_pkg::OP_XOR_FLAGS: ccr_reg <= ccr_reg ^ imm_reg[7:0];
				default: ccr_reg <= ccr_reg;
			endcase
		end else if (flag_take) begin
			ccr_reg <= fl.ccr_out;
		end
	end

	// -------------------------
	// Status outputs
	// -------------------------
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			done_reg <= 1'b0;
			sleep_reg <= 1'b0;
			ready_reg <= 1'b0;
			we_reg <= 1'b0;
			wdat_reg <= 8'h00;
		end else begin
			done_reg <= fin;
			// Mirrors the next sleep state so the pin comes from a flop
			sleep_reg <= (fin && op_reg == srf_pkg::OP_SLEEP) ||
				(st_reg == S_SLEEP && !WAKE_I);
			ready_reg <= (st_reg == S_IDLE && !INSTR_VALID_I) ||
				(fin && op_reg != srf_pkg::OP_SLEEP) || (st_reg == S_SLEEP && WAKE_I);
			we_reg <= fin && (op_reg == srf_pkg::OP_STORE_FLAGS);
			if (fin && op_reg == srf_pkg::OP_STORE_FLAGS) wdat_reg <= ccr_reg;
		end
	end

	assign INSTR_READY_O = ready_reg;
	assign DONE_O        = done_reg;
	assign SLEEP_O       = sleep_reg;
	assign CCR_O         = ccr_reg;
	assign PC_O          = pc_reg;
	assign SP_O          = sp_reg;
	assign REG_WE_O      = we_reg;
	assign REG_WDATA_O   = wdat_reg;
	assign MEM_ADDR_O    = addr_reg;
	assign MEM_WDATA_O   = mwd_reg;
	assign MEM_RD_O      = rd_reg;
	assign MEM_WR_O      = wr_reg;
	assign MEM_WORD_O    = word_reg;

	// -------------------------
	// Checks
	// -------------------------
	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I || start) begin
			cnt_reg <= 11'h001;
			waited_reg <= 1'b0;
		end else if (st_reg == S_RUN) begin
			cnt_reg <= cnt_reg + 11'h001;
			if (is_mem && sub_reg[0] && !MEM_READY_I) waited_reg <= 1'b1;
		end
	end

	always_comb begin
		case (op_reg)
			srf_pkg::OP_CALL_REG: exp_states = `SRF_ST_CALL_REG;
			srf_pkg::OP_CALL_ABS: exp_states = `SRF_ST_CALL_ABS;
			srf_pkg::OP_CALL_MEM: exp_states = `SRF_ST_CALL_MEM;
			srf_pkg::OP_RET: exp_states = `SRF_ST_RET;
			srf_pkg::OP_RET_EXC: exp_states = `SRF_ST_RET_EXC;
			srf_pkg::OP_BLOCK_MOVE: exp_states = {1'b0, bmc_reg, 2'b00} + `SRF_ST_BM_BASE;
			default: exp_states = `SRF_ST_SHORT;
		endcase
	end

	state_count_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		fin && !waited_reg |-> cnt_reg == exp_states)
		else $error("instruction state count wrong");
	call_reg_states_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		start && INSTR_OP_I == srf_pkg::OP_CALL_REG && MEM_READY_I ##1 MEM_READY_I [*5]
		|-> ##2 DONE_O && PC_O == $past(rn_reg) && $stable(CCR_O))
		else $error("register call timing or target wrong");
	call_abs_target_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		fin && op_reg == srf_pkg::OP_CALL_ABS |=> PC_O == $past(imm_reg) && SP_O == $past(SP_O))
		else $error("absolute call target wrong");
	call_mem_target_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		step && ph == srf_pkg::PH_VEC ##1 MEM_READY_I [*3] |=> fin ##1 PC_O == $past(MEM_RDATA_I, 5))
		else $error("vector call target wrong");
	ret_flags_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		st_reg == S_RUN && op_reg == srf_pkg::OP_RET |=> $stable(CCR_O))
		else $error("return changed flags");
	ret_exc_flags_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		step && ph == srf_pkg::PH_POPCCR |=> CCR_O == $past(MEM_RDATA_I[7:0]) && SP_O == $past(SP_O) + 16'h0002)
		else $error("exception return flags wrong");
	sleep_entry_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		start && INSTR_OP_I == srf_pkg::OP_SLEEP |-> ##3 SLEEP_O && $stable(CCR_O))
		else $error("sleep not entered after two states");
	load_flags_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		start && INSTR_OP_I == srf_pkg::OP_LOAD_FLAGS_IMM |-> ##3 CCR_O == $past(INSTR_IMM_I[7:0], 3))
		else $error("immediate flag load wrong");
	store_flags_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		fin && op_reg == srf_pkg::OP_STORE_FLAGS |=> REG_WE_O && REG_WDATA_O == CCR_O && !$past(REG_WE_O))
		else $error("flag store wrong");
	nop_step_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		fin && op_reg == srf_pkg::OP_NOP |=> PC_O == $past(PC_O) + 16'h0002 && $stable(SP_O))
		else $error("no-operation changed state");
	stack_even_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		MEM_WORD_O |-> !MEM_ADDR_O[0] && (MEM_RD_O || MEM_WR_O))
		else $error("stack word at odd address");
endmodule
`default_nettype wire

// ### srf_mem_model.sv
// Memory model answering the execution unit on its internal bus
`timescale 1ns/10ps
`default_nettype none
module srf_mem_model (
	input  wire logic        clk_i,
	input  wire logic        rd_i,
	input  wire logic        wr_i,
	input  wire logic        word_i,
	input  wire logic        slow_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [15:0] wdata_i,
	output logic             ready_o,
	output logic [15:0]      rdata_o
);
	bit   [7:0]  mem [0:65535];
	logic [15:0] last_reg = 16'h0000;
	logic        tog_reg  = 1'b0;
	logic [15:0] lo_addr;
	// Idle read data flips every cycle so a late sample cannot match by luck
	assign lo_addr = addr_i | 16'h0001;
	assign ready_o = !slow_i | tog_reg;
	assign rdata_o = !rd_i ? ~last_reg : word_i ? {mem[addr_i], mem[lo_addr]} : {8'h00, mem[addr_i]};
	always @(posedge clk_i) begin
		tog_reg <= ~tog_reg;
		last_reg <= rdata_o;
		if (wr_i && ready_o && word_i) begin
			mem[addr_i] <= wdata_i[15:8];
			mem[lo_addr] <= wdata_i[7:0];
		end else if (wr_i && ready_o) begin
			mem[addr_i] <= wdata_i[7:0];
		end
	end
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the subroutine and flag execution unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
	typedef struct {logic [15:0] pc; logic [15:0] sp; logic [7:0] condition_code_register; logic [15:0] cyc;} srf_note_t;
	logic              clk, rst_n, valid, wake, fvalid, slow, ready, done, sleeping, we;
	logic              rd, wr, word, mready;
	srf_pkg::srf_op_t  op;
	srf_pkg::srf_fop_t fop;
	logic [15:0]       imm, rg, src, dst, fa, fb, rdata, pc, sp, addr, wdata, cyc, epc, esp, r, p;
	logic [7:0]        cnt, condition_code_register, wd, eccr;
	int                err_total, check_count, seed;
	srf_note_t         q[$];
	srf_note_t         nt;
	logic [7:0]        rq[$];

	srf_exec_unit dut (.SYS_CLK_I(clk), .RESETN_I(rst_n), .INSTR_VALID_I(valid),
		.INSTR_OP_I(op), .INSTR_IMM_I(imm), .INSTR_REG_I(rg), .BM_SRC_I(src), .BM_DST_I(dst),
		.BM_COUNT_I(cnt), .WAKE_I(wake), .FLAG_VALID_I(fvalid), .FLAG_OP_I(fop), .FLAG_A_I(fa),
		.FLAG_B_I(fb), .MEM_RDATA_I(rdata), .MEM_READY_I(mready), .INSTR_READY_O(ready),
		.DONE_O(done), .SLEEP_O(sleeping), .CCR_O(condition_code_register), .PC_O(pc), .SP_O(sp), .REG_WE_O(we),
		.REG_WDATA_O(wd), .MEM_ADDR_O(addr), .MEM_WDATA_O(wdata), .MEM_RD_O(rd), .MEM_WR_O(wr),
		.MEM_WORD_O(word));
	srf_mem_model mdl (.clk_i(clk), .rd_i(rd), .wr_i(wr), .word_i(word), .slow_i(slow),
		.addr_i(addr), .wdata_i(wdata), .ready_o(mready), .rdata_o(rdata));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %0t %h %h", $time, g, e);
		end
	endtask
	task automatic end_of_test;
		if (err_total == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	function automatic logic [15:0] rd16(input logic [15:0] a);
		return {mdl.mem[a], mdl.mem[a + 16'h0001]};
	endfunction
	task automatic issue(input srf_pkg::srf_op_t o, input logic [15:0] i, input logic [15:0] g,
		input int n, input logic [15:0] npc, input logic [15:0] nsp, input logic [7:0] nccr);
		do @(negedge clk); while (ready !== 1'b1);
		@(posedge clk);
		valid <= 1'b1;
		op <= o;
		imm <= i;
		rg <= g;
		@(negedge clk);
		// Slow memory stretches phases by an uncounted amount, so timing is skipped there
		q.push_back('{npc, nsp, nccr, slow ? 16'h0000 : cyc + 16'(n + 1)});
		@(posedge clk);
		valid <= 1'b0;
		epc = npc;
		esp = nsp;
		eccr = nccr;
	endtask
	task automatic settle;
		repeat (80) begin
			@(negedge clk);
			if (ready === 1'b1 && q.size() == 0)
				break;
		end
	endtask
	task automatic flagop(input srf_pkg::srf_op_t o, input logic [15:0] i, input logic [7:0] c);
		issue(o, i, i, 2, epc + 16'h0002, esp, c);
	endtask
	task automatic fl(input logic [7:0] pre, input srf_pkg::srf_fop_t f, input logic [15:0] a,
		input logic [15:0] b, input logic [7:0] e);
		flagop(srf_pkg::OP_LOAD_FLAGS_IMM, {8'h00, pre}, pre);
		settle();
		@(posedge clk);
		fvalid <= 1'b1;
		fop <= f;
		fa <= a;
		fb <= b;
		@(posedge clk);
		fvalid <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		cmp({8'h00, condition_code_register}, {8'h00, e});
		eccr = e;
	endtask

	// ----------------------------------------
	// Clock, cycle count, monitor, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 16'h0001;
	always @(negedge clk) begin
		if (done === 1'b1 && q.size() == 0) begin
			cmp(16'hFFFF, 16'h0000);
		end else if (done === 1'b1) begin
			nt = q.pop_front();
			cmp(pc, nt.pc);
			cmp(sp, nt.sp);
			cmp({8'h00, condition_code_register}, {8'h00, nt.condition_code_register});
			if (nt.cyc !== 16'h0000)
				cmp(cyc, nt.cyc);
		end
		if (we === 1'b1)
			cmp({8'h00, wd}, {8'h00, rq.pop_front()});
	end
	initial begin
		#(40 * 8000);
		err_total++;
		end_of_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 86;
		err_total = 0;
		check_count = 0;
		cyc = 16'h0000;
		{rst_n, valid, wake, fvalid, slow} = 5'h00;
		op = srf_pkg::OP_NOP;
		fop = srf_pkg::FOP_ADD_W;
		{imm, rg, fa, fb, cnt} = 72'h0;
		src = 16'h0100;
		dst = 16'h0200;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		cmp(pc, 16'h0000);
		cmp(sp, 16'hFF00);
		cmp({8'h00, condition_code_register}, 16'h0080);
		epc = 16'h0000;
		esp = 16'hFF00;
		eccr = 8'h80;
		for (int k = 0; k < 4; k++) begin
			r = 16'($random(seed));
			flagop(srf_pkg::OP_LOAD_FLAGS_IMM, r, r[7:0]);
			r = 16'($random(seed));
			flagop(srf_pkg::OP_OR_FLAGS, r, eccr | r[7:0]);
			flagop(srf_pkg::OP_AND_FLAGS, ~r, eccr & ~r[7:0]);
			flagop(srf_pkg::OP_XOR_FLAGS, r, eccr ^ r[7:0]);
			rq.push_back(eccr);
			flagop(srf_pkg::OP_STORE_FLAGS, ~r, eccr);
			flagop(srf_pkg::OP_LOAD_FLAGS_REG, r, r[7:0]);
			flagop(srf_pkg::OP_NOP, r, eccr);
		end
		mdl.mem[16'h0010] = 8'h12;
		mdl.mem[16'h0011] = 8'h34;
		for (int s = 0; s < 2; s++) begin
			settle();
			slow = s[0];
			p = epc;
			issue(srf_pkg::OP_CALL_ABS, 16'h4000, 16'h0000, 8, 16'h4000, esp - 16'h0002, eccr);
			settle();
			cmp(rd16(esp), p + 16'h0004);
			p = epc;
			r = 16'($random(seed));
			issue(srf_pkg::OP_CALL_REG, 16'h0000, r, 6, r, esp - 16'h0002, eccr);
			settle();
			cmp(rd16(esp), p + 16'h0002);
			p = epc;
			issue(srf_pkg::OP_CALL_MEM, 16'h0011, 16'h0000, 8, 16'h1234, esp - 16'h0002, eccr);
			settle();
			cmp(rd16(esp), p + 16'h0002);
			repeat (3) issue(srf_pkg::OP_RET, 16'h0000, 16'h0000, 8, rd16(esp), esp + 16'h0002, eccr);
		end
		settle();
		slow = 1'b0;
		{mdl.mem[esp], mdl.mem[esp + 16'h0001]} = 16'h006B;
		{mdl.mem[esp + 16'h0002], mdl.mem[esp + 16'h0003]} = 16'h2468;
		issue(srf_pkg::OP_RET_EXC, 16'h0000, 16'h0000, 10, 16'h2468, esp + 16'h0004, 8'h6B);
		for (int n = 3; n >= 0; n -= 3) begin
			for (int b = 0; b < 3; b++)
				mdl.mem[src + 16'(b)] = 8'($random(seed));
			settle();
			@(posedge clk);
			cnt <= 8'(n);
			issue(srf_pkg::OP_BLOCK_MOVE, 16'h0000, 16'h0000, 4 * n + 8, epc + 16'h0002, esp, eccr);
			settle();
			for (int b = 0; b < n; b++)
				cmp({8'h00, mdl.mem[dst + 16'(b)]}, {8'h00, mdl.mem[src + 16'(b)]});
		end
		issue(srf_pkg::OP_SLEEP, 16'h0000, 16'h0000, 2, epc + 16'h0002, esp, eccr);
		repeat (4) @(negedge clk);
		cmp({15'h0000, sleeping}, 16'h0001);
		@(posedge clk);
		valid <= 1'b1;
		op <= srf_pkg::OP_NOP;
		@(posedge clk);
		valid <= 1'b0;
		repeat (4) @(negedge clk);
		cmp(pc, epc);
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		cmp({15'h0000, sleeping}, 16'h0000);
		fl(8'h00, srf_pkg::FOP_ADD_W, 16'h0800, 16'h0800, 8'h20);
		fl(8'h20, srf_pkg::FOP_ADD_W, 16'h0700, 16'h0100, 8'h00);
		fl(8'h00, srf_pkg::FOP_SUB_W, 16'h0000, 16'h0001, 8'h20);
		fl(8'h04, srf_pkg::FOP_ADD_CARRY, 16'h0000, 16'h0000, 8'h04);
		fl(8'h04, srf_pkg::FOP_SUB_BORROW, 16'h0005, 16'h0002, 8'h00);
		fl(8'h00, srf_pkg::FOP_DEC_ADD, 16'h009A, 16'h0000, 8'h01);
		fl(8'h00, srf_pkg::FOP_DEC_ADD, 16'h0012, 16'h0000, 8'h00);
		fl(8'h04, srf_pkg::FOP_DIV_U, 16'h1234, 16'h0080, 8'h08);
		fl(8'h0C, srf_pkg::FOP_DIV_U, 16'h1234, 16'h0001, 8'h00);
		fl(8'h20, srf_pkg::FOP_SUB_W, 16'h0800, 16'h0100, 8'h00);
		fl(8'h04, srf_pkg::FOP_ADD_CARRY, 16'h0001, 16'h0000, 8'h00);
		fl(8'h01, srf_pkg::FOP_SUB_BORROW, 16'h0001, 16'h0000, 8'h01);
		fl(8'h01, srf_pkg::FOP_DEC_SUB, 16'h0066, 16'h0000, 8'h01);
		fl(8'h00, srf_pkg::FOP_DEC_SUB, 16'h0034, 16'h0000, 8'h00);
		settle();
		cmp(16'(q.size()), 16'h0000);
		end_of_test();
	end
endmodule
`default_nettype wire
